// file: hdl/adcrp_consts.vh
// Constants for the converter readout port and power-down logic
// Behaviour
// - Word mode: bit 15 pin drives result MSB
// - Selector high: bit 15 pin picks serial/byte
// - Word mode: bit 14 pin drives bit 14
// - Byte mode: bit 14 pin sets byte order
// - Word mode: pins 13..9 drive bits 13..9
// - Word mode: bit 8 pin drives bit 8
// - Word mode: bit 7 pin drives bit 7
// - Word mode: low pins drive bits 6..0
// - Byte mode: bit 8 pin always undriven
// - Byte mode: bit 7 pin carries byte MSB
// - Byte mode: two reads per channel result
// - Serial: line A channels 1-4, B 5-8
// - Power-down low enters standby or shutdown
// - Standby: front end off, reference on
// - Shutdown: everything powered down
// - Select rise floats bus, fall starts frame
// - Serial clock is read strobe, falling edge
`ifndef ADCRP_CONSTS_VH
`define ADCRP_CONSTS_VH

// Register map
`define ADCRP_RES_BASE  8'h00
`define ADCRP_RES_END   8'h20
`define ADCRP_STATUS    8'h20
`define ADCRP_CTRL      8'h24

// Status fields
`define ADCRP_ST_MODE_LO  0
`define ADCRP_ST_FRAME    2
`define ADCRP_ST_CH_LO    3
`define ADCRP_ST_POWER_DOWN_N     6
`define ADCRP_ST_SHDN     7
`define ADCRP_ST_SETTLED  8
`define ADCRP_ST_RSTNEED  9

// Control fields
`define ADCRP_CTRL_CLRRST 0

// Readout modes
`define ADCRP_MODE_WORD   2'h0
`define ADCRP_MODE_BYTE   2'h1
`define ADCRP_MODE_SER    2'h2

// Reset values
`define ADCRP_RES_RST     16'h0000

// Timing
`define ADCRP_CLK_MHZ     125
`define ADCRP_POWER_DOWN_N_US     100
`define ADCRP_SHDN_MS     13
`define ADCRP_POWER_DOWN_N_CYC    (`ADCRP_POWER_DOWN_N_US * `ADCRP_CLK_MHZ)
`define ADCRP_SHDN_CYC    (`ADCRP_SHDN_MS * 1000 * `ADCRP_CLK_MHZ)
`define ADCRP_BITS_LAST   4'hF

`endif

// file: hdl/adcrp_sync.v
// Two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module adcrp_sync #(
  parameter         W    = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  // Clock and reset
  input  wire         clk,
  input  wire         rst_n,
  // Data
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);

reg [W-1:0] s1_q;
reg [W-1:0] s2_q;

always @(posedge clk or negedge rst_n) begin
  if (!rst_n) begin
    s1_q <= INIT;
    s2_q <= INIT;
  end else begin
    s1_q <= d;
    s2_q <= s1_q;
  end
end

assign q = s2_q;

endmodule // adcrp_sync

// file: hdl/adcrp_top.v
// Readout port pin logic, power-down control and APB register file
`timescale 1ns/1ps
`include "adcrp_consts.vh"
module adcrp_top #(
  parameter [23:0] POWER_DOWN_N_CYC = `ADCRP_POWER_DOWN_N_CYC,
  parameter [23:0] SHDN_CYC = `ADCRP_SHDN_CYC
) (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Host strobes
  input  wire        chip_select_n,
  input  wire        read_strobe_n,
  // Configuration pins
  input  wire        interface_selector,
  input  wire        power_down_n,
  input  wire        input_span_select,
  // Bit 15 pin
  input  wire        bit15_byte_select_i,
  output wire        bit15_byte_select_o,
  output wire        bit15_byte_select_oe,
  // Bit 14 pin
  input  wire        bit14_byte_order_i,
  output wire        bit14_byte_order_o,
  output wire        bit14_byte_order_oe,
  // Bits 13 to 9
  output wire [4:0]  data_bits_13_to_9_o,
  output wire        data_bits_13_to_9_oe,
  // Bit 8 pin
  output wire        bit8_serial_out_b_o,
  output wire        bit8_serial_out_b_oe,
  // Bit 7 pin
  output wire        bit7_serial_out_a_o,
  output wire        bit7_serial_out_a_oe,
  // Bits 6 to 0
  output wire [6:0]  data_bits_6_to_0_o,
  output wire        data_bits_6_to_0_oe,
  // Power domains
  output wire        front_end_on,
  output wire        reference_on
);

////////////////////////////////////////////////////////////////////////
// Pin synchronisation

wire [6:0] pin_s;
wire       cs_n_s;
wire       rd_n_s;
wire       sel_s;
wire       b15_s;
wire       b14_s;
wire       pd_n_s;
wire       span_s;

adcrp_sync #(
  .W    (7),
  .INIT (7'h07)
) u_sync (
  .clk   (pclk),
  .rst_n (presetn),
  .d     ({input_span_select, bit14_byte_order_i, bit15_byte_select_i,
           interface_selector, power_down_n, read_strobe_n, chip_select_n}),
  .q     (pin_s)
);

assign cs_n_s = pin_s[0];
assign rd_n_s = pin_s[1];
assign pd_n_s = pin_s[2];
assign sel_s  = pin_s[3];
assign b15_s  = pin_s[4];
assign b14_s  = pin_s[5];
assign span_s = pin_s[6];

////////////////////////////////////////////////////////////////////////
// Mode decode and edges

reg        cs_prev_q;
reg        rd_prev_q;
reg        pd_prev_q;
reg [1:0]  mode;

always @* begin
  if (!sel_s)
    mode = `ADCRP_MODE_WORD;
  else if (b15_s)
    mode = `ADCRP_MODE_BYTE;
  else
    mode = `ADCRP_MODE_SER;
end

wire cs_fall = cs_prev_q & ~cs_n_s;
wire cs_rise = ~cs_prev_q & cs_n_s;
wire rd_fall = rd_prev_q & ~rd_n_s;
wire rd_rise = ~rd_prev_q & rd_n_s;
wire pd_rise = ~pd_prev_q & pd_n_s;

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    cs_prev_q <= 1'b1;
    rd_prev_q <= 1'b1;
    pd_prev_q <= 1'b1;
  end else begin
    cs_prev_q <= cs_n_s;
    rd_prev_q <= rd_n_s;
    pd_prev_q <= pd_n_s;
  end
end

////////////////////////////////////////////////////////////////////////
// Conversion results

reg [15:0] result_q [0:7];
reg        frame_q;
reg [2:0]  ch_q;
reg        ph_q;
reg [3:0]  bit_q;
reg [15:0] sha_q;
reg [15:0] shb_q;
reg [15:0] out_q;
reg [15:0] oe_q;

wire [2:0]  idx     = cs_fall ? 3'h0 : ch_q;
wire        ph      = cs_fall ? 1'b0 : ph_q;
wire [15:0] word    = result_q[idx];
wire        hi_byte = b14_s ? ~ph : ph;
wire [1:0]  ch_nx   = ch_q[1:0] + 2'h1;
wire        ser_end = (ch_q[1:0] == 2'h3);
wire        bit_end = (bit_q == `ADCRP_BITS_LAST);

wire [15:0] nxt_a = bit_end ? (ser_end ? 16'h0000 : result_q[{1'b0, ch_nx}])
                            : {sha_q[14:0], 1'b0};
wire [15:0] nxt_b = bit_end ? (ser_end ? 16'h0000 : result_q[{1'b1, ch_nx}])
                            : {shb_q[14:0], 1'b0};

////////////////////////////////////////////////////////////////////////
// Readout sequencing

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    frame_q <= 1'b0;
    ch_q    <= 3'h0;
    ph_q    <= 1'b0;
    bit_q   <= 4'h0;
    sha_q   <= 16'h0000;
    shb_q   <= 16'h0000;
    out_q   <= 16'h0000;
    oe_q    <= 16'h0000;
  end else begin
    if (cs_fall) begin
      frame_q <= 1'b1;
      ch_q    <= 3'h0;
      ph_q    <= 1'b0;
      bit_q   <= 4'h0;
      if (mode == `ADCRP_MODE_SER) begin
        sha_q     <= result_q[0];
        shb_q     <= result_q[4];
        out_q[7]  <= result_q[0][15];
        out_q[8]  <= result_q[4][15];
        oe_q      <= 16'h0180;
      end
    end
    if (!cs_n_s && rd_fall) begin
      case (mode)
        `ADCRP_MODE_WORD: begin
          out_q <= word;
          oe_q  <= 16'hFFFF;
        end
        `ADCRP_MODE_BYTE: begin
          out_q[7:0] <= hi_byte ? word[15:8] : word[7:0];
          oe_q       <= 16'h00FF;
        end
        `ADCRP_MODE_SER: begin
          if (!cs_fall) begin
            sha_q    <= nxt_a;
            shb_q    <= nxt_b;
            out_q[7] <= nxt_a[15];
            out_q[8] <= nxt_b[15];
            bit_q    <= bit_q + 4'h1;
            if (bit_end && !ser_end)
              ch_q <= ch_q + 3'h1;
          end
        end
        default: begin
          oe_q <= 16'h0000;
        end
      endcase
    end
    if (!cs_n_s && rd_rise && mode != `ADCRP_MODE_SER) begin
      oe_q <= 16'h0000;
      if (mode == `ADCRP_MODE_BYTE) begin
        ph_q <= ~ph_q;
        if (ph_q)
          ch_q <= ch_q + 3'h1;
      end else begin
        ch_q <= ch_q + 3'h1;
      end
    end
    if (cs_rise) begin
      frame_q <= 1'b0;
      oe_q    <= 16'h0000;
    end
  end
end

assign bit15_byte_select_o  = out_q[15];
assign bit15_byte_select_oe = oe_q[15];
assign bit14_byte_order_o   = out_q[14];
assign bit14_byte_order_oe  = oe_q[14];
assign data_bits_13_to_9_o  = out_q[13:9];
assign data_bits_13_to_9_oe = oe_q[13];
assign bit8_serial_out_b_o  = out_q[8];
assign bit8_serial_out_b_oe = oe_q[8];
assign bit7_serial_out_a_o  = out_q[7];
assign bit7_serial_out_a_oe = oe_q[7];
assign data_bits_6_to_0_o   = out_q[6:0];
assign data_bits_6_to_0_oe  = oe_q[6];

////////////////////////////////////////////////////////////////////////
// Power-down control

reg        fe_on_q;
reg        ref_on_q;
reg        power_down_n_q;
reg        shdn_q;
reg        was_shdn_q;
reg [23:0] settle_q;
reg        settled_q;
reg        rst_need_q;
wire       clr_rst;

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    fe_on_q    <= 1'b1;
    ref_on_q   <= 1'b1;
    power_down_n_q     <= 1'b0;
    shdn_q     <= 1'b0;
    was_shdn_q <= 1'b0;
    settle_q   <= 24'h000000;
    settled_q  <= 1'b1;
    rst_need_q <= 1'b0;
  end else begin
    if (!pd_n_s) begin
      fe_on_q    <= 1'b0;
      ref_on_q   <= span_s;
      power_down_n_q     <= span_s;
      shdn_q     <= ~span_s;
      was_shdn_q <= ~span_s;
      settled_q  <= 1'b0;
      settle_q   <= 24'h000000;
    end else if (pd_rise) begin
      fe_on_q  <= 1'b1;
      ref_on_q <= 1'b1;
      power_down_n_q   <= 1'b0;
      shdn_q   <= 1'b0;
      settle_q <= was_shdn_q ? SHDN_CYC : POWER_DOWN_N_CYC;
    end else if (settle_q != 24'h000000) begin
      settle_q <= settle_q - 24'h000001;
      if (settle_q == 24'h000001)
        settled_q <= 1'b1;
    end
    if (pd_rise && was_shdn_q)
      rst_need_q <= 1'b1;
    else if (clr_rst)
      rst_need_q <= 1'b0;
  end
end

assign front_end_on = fe_on_q;
assign reference_on = ref_on_q;

////////////////////////////////////////////////////////////////////////
// APB register file

reg        pready_q;
reg        pslverr_q;
reg [31:0] prdata_q;
reg [31:0] rd_val;
reg        hit;

wire setup  = psel & ~penable;
wire access = psel & penable & pready_q;
wire is_res = (paddr < `ADCRP_RES_END);
wire wr_ok  = access & pwrite & hit;

assign clr_rst = wr_ok & (paddr == `ADCRP_CTRL) & pwdata[`ADCRP_CTRL_CLRRST];

always @* begin
  rd_val = 32'h00000000;
  hit    = (paddr[1:0] == 2'h0);
  if (is_res)
    rd_val = {16'h0000, result_q[paddr[4:2]]};
  else if (paddr == `ADCRP_STATUS) begin
    rd_val[`ADCRP_ST_MODE_LO+1:`ADCRP_ST_MODE_LO] = mode;
    rd_val[`ADCRP_ST_FRAME]                   = frame_q;
    rd_val[`ADCRP_ST_CH_LO+2:`ADCRP_ST_CH_LO]   = ch_q;
    rd_val[`ADCRP_ST_POWER_DOWN_N]                    = power_down_n_q;
    rd_val[`ADCRP_ST_SHDN]                    = shdn_q;
    rd_val[`ADCRP_ST_SETTLED]                 = settled_q;
    rd_val[`ADCRP_ST_RSTNEED]                 = rst_need_q;
  end else if (paddr != `ADCRP_CTRL)
    hit = 1'b0;
end

always @(posedge pclk or negedge presetn) begin : apb_p
  integer i;
  if (!presetn) begin
    pready_q  <= 1'b0;
    pslverr_q <= 1'b0;
    prdata_q  <= 32'h00000000;
    for (i = 0; i < 8; i = i + 1)
      result_q[i] <= `ADCRP_RES_RST;
  end else begin
    pready_q  <= setup;
    pslverr_q <= setup & ~hit;
    prdata_q  <= (setup & ~pwrite & hit) ? rd_val : 32'h00000000;
    if (wr_ok && is_res)
      result_q[paddr[4:2]] <= pwdata[15:0];
  end
end

assign pready  = pready_q;
assign pslverr = pslverr_q;
assign prdata  = prdata_q;

endmodule // adcrp_top

// file: testbench/adcrp_chk.sv
// Assertion checker for the readout pins and power control
`timescale 1ns/1ps
module adcrp_chk (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Strobes and configuration
  input wire chip_select_n,
  input wire read_strobe_n,
  input wire interface_selector,
  input wire power_down_n,
  input wire input_span_select,
  input wire bit15_byte_select_i,
  // Enables and power
  input wire bit15_byte_select_oe,
  input wire bit14_byte_order_oe,
  input wire data_bits_13_to_9_oe,
  input wire bit8_serial_out_b_oe,
  input wire bit7_serial_out_a_oe,
  input wire data_bits_6_to_0_oe,
  input wire front_end_on,
  input wire reference_on
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire word_rd = !interface_selector && !chip_select_n && !read_strobe_n;
  wire byte_m  = interface_selector && bit15_byte_select_i;
  wire ser_m   = interface_selector && !bit15_byte_select_i;
  wire any_oe  = bit15_byte_select_oe | bit14_byte_order_oe | data_bits_13_to_9_oe | bit8_serial_out_b_oe
                 | bit7_serial_out_a_oe | data_bits_6_to_0_oe;
  AST_WORD_HI: assert property (word_rd [*6] |-> bit15_byte_select_oe && bit14_byte_order_oe)
    else $error("word mode upper pins not driven");
  AST_WORD_LO: assert property (word_rd [*6] |-> data_bits_13_to_9_oe
    && bit8_serial_out_b_oe && bit7_serial_out_a_oe && data_bits_6_to_0_oe)
    else $error("word mode lower pins not driven");
  AST_SEL_IN: assert property (interface_selector [*6] |-> !bit15_byte_select_oe
    && !bit14_byte_order_oe) else $error("control pin driven outside word mode");
  AST_BYTE_B8: assert property (byte_m [*6] |-> !bit8_serial_out_b_oe)
    else $error("bit 8 pin driven in byte mode");
  AST_BYTE_B7: assert property (byte_m [*6] |-> bit7_serial_out_a_oe == data_bits_6_to_0_oe
    && !data_bits_13_to_9_oe) else $error("byte lane enables differ");
  AST_SER_OE: assert property ((ser_m && !chip_select_n) [*6] |-> bit7_serial_out_a_oe
    && bit8_serial_out_b_oe) else $error("serial lines not driven in frame");
  AST_CS_FLOAT: assert property (chip_select_n [*6] |-> !any_oe)
    else $error("pin driven while deselected");
  AST_POWER_DOWN_N: assert property ((!power_down_n && input_span_select) [*5] |-> !front_end_on
    && reference_on) else $error("standby power state wrong");
  AST_SHDN: assert property ((!power_down_n && !input_span_select) [*5] |-> !front_end_on && !reference_on)
    else $error("shutdown power state wrong");
  AST_WAKE: assert property ($rose(power_down_n) |-> ##[2:5] (front_end_on && reference_on))
    else $error("no power up after wake");
  cover property (word_rd [*6]);
  cover property ((byte_m && !read_strobe_n && !chip_select_n) [*6]);
  cover property ((ser_m && !chip_select_n) [*6]);
  cover property (!power_down_n && !input_span_select);
endmodule // adcrp_chk
bind adcrp_top adcrp_chk u_chk (.pclk, .presetn, .chip_select_n, .read_strobe_n, .interface_selector,
  .power_down_n, .input_span_select, .bit15_byte_select_i, .bit15_byte_select_oe, .bit14_byte_order_oe,
  .data_bits_13_to_9_oe, .bit8_serial_out_b_oe, .bit7_serial_out_a_oe, .data_bits_6_to_0_oe,
  .front_end_on, .reference_on);

// file: testbench/adcrp_host.sv
// Host controller model: strobes, mode pins and data sampling
`timescale 1ns/1ps
module adcrp_host (
  // Strobes and mode pins
  output logic        chip_select_n,
  output logic        read_strobe_n,
  output logic        interface_selector,
  output logic        b15_drv,
  output logic        b14_drv,
  // Data pins
  input  wire  [15:0] bus,
  input  wire  [15:0] en
);
  localparam int HALF = 40;
  initial begin
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
    interface_selector = 1'b0;
    b15_drv = 1'b0;
    b14_drv = 1'b0;
  end
  // Mode pins change only between frames
  task automatic set_mode(input logic s, input logic hi, input logic lo);
    interface_selector <= s;
    b15_drv <= hi;
    b14_drv <= lo;
    #(4 * HALF);
  endtask
  task automatic frame(input logic on);
    chip_select_n <= !on;
    #(2 * HALF);
  endtask
  // Parallel read: sample late in the low phase
  task automatic strobe(output logic [15:0] d, output logic [15:0] e);
    read_strobe_n <= 1'b0;
    #HALF;
    d = bus;
    e = en;
    read_strobe_n <= 1'b1;
    #HALF;
  endtask
  // Serial read: MSB first, next bit after each fall
  task automatic shift(output logic [15:0] a, output logic [15:0] b);
    for (int i = 15; i >= 0; i--) begin
      a[i] = bus[7];
      b[i] = bus[8];
      read_strobe_n <= 1'b0;
      #HALF;
      read_strobe_n <= 1'b1;
      #HALF;
    end
  endtask
endmodule // adcrp_host

// file: testbench/test_adc_readout_port_and_powerdown.sv
// Testbench for the readout port and power-down block
`timescale 1ns/1ps
module test_adc_readout_port_and_powerdown;
  logic        pclk, presetn, psel, penable, pwrite, pd_n, span, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, rd;
  logic [15:0] d, e, a, b, v;
  wire         cs_n, rd_n, sel, b15h, b14h, b15o, b15e, b14o, b14e, b8o, b8e, b7o, b7e, e139, e60;
  wire         fe, rf, pready, pslverr;
  wire [4:0]   d139;
  wire [6:0]   d60;
  wire [31:0]  prdata;
  wire [15:0]  bus = {b15o, b14o, d139, b8o, b7o, d60};
  wire [15:0]  en = {b15e, b14e, {5{e139}}, b8e, b7e, {7{e60}}};
  int          mismatches = 0, num_checks = 0;
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  adcrp_top #(.POWER_DOWN_N_CYC(24'd20), .SHDN_CYC(24'd50)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chip_select_n(cs_n), .read_strobe_n(rd_n), .interface_selector(sel),
    .power_down_n(pd_n), .input_span_select(span), .bit15_byte_select_i(b15e ? b15o : b15h),
    .bit15_byte_select_o(b15o), .bit15_byte_select_oe(b15e), .bit14_byte_order_i(b14e ? b14o : b14h),
    .bit14_byte_order_o(b14o), .bit14_byte_order_oe(b14e), .data_bits_13_to_9_o(d139),
    .data_bits_13_to_9_oe(e139), .bit8_serial_out_b_o(b8o), .bit8_serial_out_b_oe(b8e),
    .bit7_serial_out_a_o(b7o), .bit7_serial_out_a_oe(b7e), .data_bits_6_to_0_o(d60),
    .data_bits_6_to_0_oe(e60), .front_end_on(fe), .reference_on(rf));
  adcrp_host host (.chip_select_n(cs_n), .read_strobe_n(rd_n), .interface_selector(sel), .b15_drv(b15h),
    .b14_drv(b14h), .bus(bus), .en(en));
  ////////////////////////////////////////////////////////////
  function automatic logic [15:0] val(input int i);
    return 16'h01A5 + 16'(i) * 16'h2F13;
  endfunction
  task automatic chk(input string nm, input logic [63:0] ex, input logic [63:0] got);
    num_checks++;
    if (got !== ex) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    stop_test;
  end
  ////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    pd_n = 1'b1;
    span = 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++)
      apb(1'b1, 8'(4 * i), {16'h0, val(i)});
    apb(1'b0, 8'h1C, 32'h0);
    chk("result", val(7), rd);
    apb(1'b0, 8'h28, 32'h0);
    chk("unmapped", 33'h1_0000_0000, {err, rd});
    $display("test registers done");
    host.frame(1'b1);
    for (int i = 0; i < 8; i++) begin
      host.strobe(d, e);
      chk("word", {val(i), 16'hFFFF}, {d, e});
    end
    host.frame(1'b0);
    chk("float", 16'h0, en);
    v = val(0);
    for (int o = 0; o < 2; o++) begin
      host.set_mode(1'b1, 1'b1, o[0]);
      host.frame(1'b1);
      host.strobe(d, e);
      host.strobe(a, b);
      host.frame(1'b0);
      chk("bytes", {(o ? v : {v[7:0], v[15:8]}), 32'h00FF00FF}, {d[7:0], a[7:0], e, b});
    end
    host.set_mode(1'b1, 1'b0, 1'b0);
    apb(1'b0, 8'h20, 32'h0);
    chk("mode", 2, rd & 3);
    host.frame(1'b1);
    host.shift(a, b);
    host.frame(1'b0);
    chk("serial", {val(0), val(4)}, {a, b});
    host.set_mode(1'b0, 1'b0, 1'b0);
    $display("test readout done");
    apb(1'b0, 8'h20, 32'h0);
    chk("idle", 32'h100, rd & 32'h3C0);
    pd_n <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("standby", 2'b01, {fe, rf});
    apb(1'b0, 8'h20, 32'h0);
    chk("st_power_down_n", 32'h040, rd & 32'h3C0);
    pd_n <= 1'b1;
    apb(1'b0, 8'h20, 32'h0);
    chk("early", 0, rd & 32'h100);
    repeat (30) @(posedge pclk);
    apb(1'b0, 8'h20, 32'h0);
    chk("settled", 32'h100, rd & 32'h3C0);
    span <= 1'b0;
    pd_n <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("shutdown", 2'b00, {fe, rf});
    apb(1'b0, 8'h20, 32'h0);
    chk("st_shdn", 32'h080, rd & 32'h3C0);
    pd_n <= 1'b1;
    repeat (60) @(posedge pclk);
    apb(1'b0, 8'h20, 32'h0);
    chk("rst_need", 32'h300, rd & 32'h3C0);
    apb(1'b1, 8'h24, 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    chk("rst_clr", 32'h100, rd & 32'h3C0);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk("after_rst", 0, rd);
    chk("rst_pwr", 2'b11, {fe, rf});
    apb(1'b0, 8'h20, 32'h0);
    chk("rst_status", 32'h100, rd & 32'h3C0);
    $display("test power done");
    stop_test;
  end
endmodule // test_adc_readout_port_and_powerdown
